// >>> src/adc_result_readout.sv
// result readout, freeze handshake and control b register on apb
// assumes conversion results and event flags arrive on pclk
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] conversion completion loads result pair
// [R2] low read freezes until high read
// [R3] software reads low byte first
// [R4] left adjust selects result justification
// [R5] result ten bits, read only, resets zero
// [R6] control b at 0x7b, enable and selector
// [R7] reserved control b bits read zero
// [R8] selected rising flag starts conversion
// [R9] selector codes map seven event sources
// [R10] left layout puts bits high
module adc_result_readout (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire adc_result_pkg::conv_result_s conv_in,
  input  wire adc_result_pkg::trig_flags_s  trig_flags,
  output logic                             conv_start,
  output logic                             cmp_mux_enable,
  output logic      [3:0]                  channel_select_bits
);
  logic [9:0] result_r;
  logic [9:0] result_nxt;
  logic [9:0] pend_r;
  logic [9:0] pend_nxt;
  logic       pend_valid_r;
  logic       pend_valid_nxt;
  logic       frozen_r;
  logic       frozen_nxt;
  logic [7:0] ctrl_b_r;
  logic [7:0] ctrl_b_nxt;
  logic [7:0] mux_sel_r;
  logic [7:0] mux_sel_nxt;
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_a_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        access;
  logic        wr;
  logic        rd;
  logic        trig_start;

  // [R4] justified byte layout
  function automatic logic [7:0] res_byte(input logic [9:0] v, input logic left,
                                          input logic high);
    logic [15:0] w;
    // [R10] left layout bits
    w = left ? {v, 6'h00} : {6'h00, v};
    res_byte = high ? w[15:8] : w[7:0];
  endfunction : res_byte

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  assign access = psel && penable && !pready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;

  adc_trigger_select u_trig (
    .pclk       (pclk),
    .presetn    (presetn),
    .flags      (trig_flags),
    .trig_sel   (ctrl_b_r[adc_result_pkg::TRIG_SEL_LSB +: adc_result_pkg::TRIG_SEL_W]),
    .auto_en    (ctrl_a_r[adc_result_pkg::AUTO_TRIG_BIT]),
    .conv_en    (ctrl_a_r[adc_result_pkg::CONV_EN_BIT]),
    .trig_start (trig_start)
  );

  // result path
  always_comb
  begin
    result_nxt     = result_r;
    pend_nxt       = pend_r;
    pend_valid_nxt = pend_valid_r;
    frozen_nxt     = frozen_r;
    // [R1] load on completion
    if (conv_in.done)
    begin
      if (frozen_r)
      begin
        // [R2] hold while frozen
        pend_nxt       = conv_in.value;
        pend_valid_nxt = 1'b1;
      end
      else
      begin
        result_nxt = conv_in.value;
      end
    end
    if (rd && hit(paddr, adc_result_pkg::RESULT_LOW_ADDR))
    begin
      // [R2] low read freezes
      frozen_nxt = 1'b1;
    end
    if (rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR))
    begin
      // [R2] high read releases
      frozen_nxt = 1'b0;
      if (conv_in.done)
      begin
        result_nxt     = conv_in.value;
        pend_valid_nxt = 1'b0;
      end
      else if (pend_valid_r)
      begin
        result_nxt     = pend_r;
        pend_valid_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // [R5] result resets zero
      result_r     <= adc_result_pkg::RESULT_RESET;
      pend_r       <= adc_result_pkg::RESULT_RESET;
      pend_valid_r <= 1'b0;
      frozen_r     <= 1'b0;
    end
    else
    begin
      result_r     <= result_nxt;
      pend_r       <= pend_nxt;
      pend_valid_r <= pend_valid_nxt;
      frozen_r     <= frozen_nxt;
    end
  end

  // register writes
  always_comb
  begin
    ctrl_b_nxt  = ctrl_b_r;
    mux_sel_nxt = mux_sel_r;
    ctrl_a_nxt  = ctrl_a_r;
    if (wr)
    begin
      // [R6] control b write
      // [R7] reserved bits masked
      if (hit(paddr, adc_result_pkg::CTRL_B_ADDR))
        ctrl_b_nxt = pwdata[7:0] & adc_result_pkg::CTRL_B_WMASK;
      if (hit(paddr, adc_result_pkg::MUX_SELECT_ADDR))
        mux_sel_nxt = pwdata[7:0] & adc_result_pkg::MUX_SELECT_WMASK;
      if (hit(paddr, adc_result_pkg::CTRL_A_ADDR))
        ctrl_a_nxt = pwdata[7:0] & adc_result_pkg::CTRL_A_WMASK;
    end
  end

  // bus answer
  always_comb
  begin
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = access;
    pslverr_nxt = 1'b0;
    if (access)
    begin
      unique case (paddr)
        adc_result_pkg::RESULT_LOW_ADDR:
          prdata_nxt[7:0] = res_byte(result_r, mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT],
                                     1'b0);
        adc_result_pkg::RESULT_HIGH_ADDR:
          prdata_nxt[7:0] = res_byte(result_r, mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT],
                                     1'b1);
        adc_result_pkg::CTRL_B_ADDR:
          prdata_nxt[7:0] = ctrl_b_r;
        adc_result_pkg::MUX_SELECT_ADDR:
          prdata_nxt[7:0] = mux_sel_r;
        adc_result_pkg::CTRL_A_ADDR:
          prdata_nxt[7:0] = ctrl_a_r;
        adc_result_pkg::STATUS_ADDR:
        begin
          prdata_nxt[adc_result_pkg::STAT_FROZEN_BIT]  = frozen_r;
          prdata_nxt[adc_result_pkg::STAT_PENDING_BIT] = pend_valid_r;
        end
        default:
          pslverr_nxt = 1'b1;
      endcase
    end
    if (!rd)
      prdata_nxt = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_b_r            <= adc_result_pkg::CTRL_B_RESET;
      mux_sel_r           <= 8'h00;
      ctrl_a_r            <= 8'h00;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      conv_start          <= 1'b0;
      cmp_mux_enable      <= 1'b0;
      channel_select_bits <= 4'h0;
    end
    else
    begin
      ctrl_b_r            <= ctrl_b_nxt;
      mux_sel_r           <= mux_sel_nxt;
      ctrl_a_r            <= ctrl_a_nxt;
      prdata              <= prdata_nxt;
      pready              <= pready_nxt;
      pslverr             <= pslverr_nxt;
      conv_start          <= trig_start;
      cmp_mux_enable      <= ctrl_b_nxt[adc_result_pkg::CMP_MUX_EN_BIT];
      channel_select_bits <= mux_sel_nxt[adc_result_pkg::CHAN_LSB +: adc_result_pkg::CHAN_W];
    end
  end

  // [R2] frozen result stable
  AST_FROZEN_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    frozen_r && !(rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR))
    |=> $stable(result_r))
    else $error("result changed while frozen");
  // [R1] completion loads result
  AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    conv_in.done && !frozen_r |=> result_r == $past(conv_in.value))
    else $error("completed result not loaded");
  // [R7] reserved bits zero
  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    (ctrl_b_r & ~adc_result_pkg::CTRL_B_WMASK) == 8'h00)
    else $error("reserved control b bit set");
  // [R6] write reaches register
  AST_CTRL_B_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    wr && hit(paddr, adc_result_pkg::CTRL_B_ADDR)
    |=> ctrl_b_r == ($past(pwdata[7:0]) & adc_result_pkg::CTRL_B_WMASK))
    else $error("control b write lost");
  // [R5] result write ignored
  AST_RESULT_RO: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    wr && !conv_in.done && !frozen_r |=> $stable(result_r))
    else $error("result changed by write");
  // [R10] left layout low byte
  AST_LEFT_LOW: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    rd && hit(paddr, adc_result_pkg::RESULT_LOW_ADDR) && mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT]
    |=> prdata[5:0] == 6'h00 && prdata[7:6] == $past(result_r[1:0]))
    else $error("left low byte layout wrong");
  // [R4] right layout high byte
  AST_RIGHT_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR) && !mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT]
    |=> prdata[7:0] == {6'h00, $past(result_r[9:8])})
    else $error("right high byte layout wrong");
  // [R2] low read freezes
  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    rd && hit(paddr, adc_result_pkg::RESULT_LOW_ADDR) |=> frozen_r)
    else $error("low read did not freeze");
  // [R4] right layout low byte
  AST_RIGHT_LOW: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    rd && hit(paddr, adc_result_pkg::RESULT_LOW_ADDR) && !mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT]
    |=> prdata[7:0] == $past(result_r[7:0]))
    else $error("right low byte layout wrong");
  // [R10] left layout high byte
  AST_LEFT_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR) && mux_sel_r[adc_result_pkg::LEFT_ADJ_BIT]
    |=> prdata[7:0] == $past(result_r[9:2]))
    else $error("left high byte layout wrong");
  // [R7] reserved bits read zero
  AST_RESERVED_READ: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    rd && hit(paddr, adc_result_pkg::CTRL_B_ADDR)
    |=> (prdata[7:0] & ~adc_result_pkg::CTRL_B_WMASK) == 8'h00)
    else $error("reserved control b bit read as one");
  // [R2] high read releases
  AST_HIGH_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR)
    |=> !frozen_r)
    else $error("high read did not release");
  // [R2] held result loaded on release
  AST_PEND_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR) && pend_valid_r && !conv_in.done
    |=> result_r == $past(pend_r))
    else $error("held result not loaded");
  // [R2] completion held while frozen
  AST_PEND_TAKE: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    frozen_r && conv_in.done && !(rd && hit(paddr, adc_result_pkg::RESULT_HIGH_ADDR))
    |=> pend_valid_r && pend_r == $past(conv_in.value))
    else $error("completion during freeze lost");
  // [R6] enable output follows write
  AST_CMP_MUX_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    wr && hit(paddr, adc_result_pkg::CTRL_B_ADDR)
    |=> cmp_mux_enable == $past(pwdata[adc_result_pkg::CMP_MUX_EN_BIT]))
    else $error("comparator mux enable output wrong");
  // [R8] trigger reaches start output
  AST_START_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    trig_start
    |=> conv_start)
    else $error("trigger did not reach start output");
  // [R4] channel output follows write
  AST_CHANNEL_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    wr && hit(paddr, adc_result_pkg::MUX_SELECT_ADDR)
    |=> channel_select_bits == $past(pwdata[adc_result_pkg::CHAN_LSB +: adc_result_pkg::CHAN_W]))
    else $error("channel select output wrong");
endmodule : adc_result_readout
`default_nettype wire

// >>> shared/adc_result_pkg.sv
// package for the converter result readout block
// assumes a 32-bit apb master and a converter core outside this block
package adc_result_pkg;
  // byte addresses (printed offset 0x7b is not a multiple of four: index kept)
  localparam logic [7:0]  CTRL_B_INDEX       = 8'h7b;
  localparam logic [11:0] CTRL_B_ADDR        = 12'h1ec;
  localparam logic [11:0] RESULT_LOW_ADDR    = 12'h000;
  localparam logic [11:0] RESULT_HIGH_ADDR   = 12'h004;
  localparam logic [11:0] MUX_SELECT_ADDR    = 12'h008;
  localparam logic [11:0] CTRL_A_ADDR        = 12'h00c;
  localparam logic [11:0] STATUS_ADDR        = 12'h010;
  localparam int          ADDR_W             = 12;
  localparam int          RESULT_W           = 10;
  // control b fields
  localparam int          CMP_MUX_EN_BIT     = 6;
  localparam int          TRIG_SEL_LSB       = 0;
  localparam int          TRIG_SEL_W         = 3;
  localparam logic [7:0]  CTRL_B_WMASK       = 8'h47;
  localparam logic [7:0]  CTRL_B_RESET       = 8'h00;
  // mux select register fields
  localparam int          LEFT_ADJ_BIT       = 5;
  localparam int          CHAN_LSB           = 0;
  localparam int          CHAN_W             = 4;
  localparam logic [7:0]  MUX_SELECT_WMASK   = 8'h2f;
  // control a fields
  localparam int          CONV_EN_BIT        = 7;
  localparam int          AUTO_TRIG_BIT      = 5;
  localparam logic [7:0]  CTRL_A_WMASK       = 8'ha0;
  // status fields
  localparam int          STAT_FROZEN_BIT    = 0;
  localparam int          STAT_PENDING_BIT   = 1;
  localparam logic [9:0]  RESULT_RESET       = 10'h000;
  localparam logic [2:0]  TRIG_FREE_RUN      = 3'h0;

  typedef struct packed {
    logic [6:0] source;   // 7 event flags, code 1..7 -> bit 0..6
  } trig_flags_s;

  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } conv_result_s;
endpackage : adc_result_pkg

// >>> src/adc_trigger_select.sv
// trigger source selection with rising-edge detection
// assumes event flags are synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_select (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire adc_result_pkg::trig_flags_s flags,
  input  wire logic [2:0]                 trig_sel,
  input  wire logic                       auto_en,
  input  wire logic                       conv_en,
  output logic                            trig_start
);
  logic [7:0] src_vec;
  logic       level_r;
  logic       level_nxt;
  logic       start_nxt;

  always_comb
  begin
    // [R9] code to source, code 0 reads a constant zero
    src_vec   = {flags.source, 1'b0};
    level_nxt = src_vec[trig_sel];
    // [R8] rising edge start
    start_nxt = auto_en && conv_en && level_nxt && !level_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_r    <= 1'b0;
      trig_start <= 1'b0;
    end
    else
    begin
      level_r    <= level_nxt;
      trig_start <= start_nxt;
    end
  end

  // [R8] free running never edges
  AST_FREE_NO_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_sel == adc_result_pkg::TRIG_FREE_RUN) |=> !trig_start) // [R8]
    else $error("trigger from free running code");
  // [R8] disabled means no trigger
  AST_AUTO_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_en |=> !trig_start) // [R8]
    else $error("trigger while auto trigger off");
endmodule : adc_trigger_select
`default_nettype wire

// >>> test/adc_result_readout_tb_top.sv
// self-checking bench for the converter result readout block
// assumes the design package and the readout block are compiled first
`timescale 1ns/1ns
`default_nettype none
module adc_result_readout_tb_top;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        err;
  } row_s;
  localparam row_s ROWS [8] = '{
    '{1'b0, adc_result_pkg::CTRL_B_ADDR, 8'h00, 8'h00, 1'b0},
    '{1'b1, adc_result_pkg::CTRL_B_ADDR, 8'hff, 8'h00, 1'b0},
    '{1'b0, adc_result_pkg::CTRL_B_ADDR, 8'h00, 8'h47, 1'b0},
    '{1'b1, adc_result_pkg::RESULT_LOW_ADDR, 8'hff, 8'h00, 1'b0},
    '{1'b0, adc_result_pkg::RESULT_LOW_ADDR, 8'h00, 8'h00, 1'b0},
    '{1'b0, adc_result_pkg::RESULT_HIGH_ADDR, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h3fc, 8'h00, 8'h00, 1'b1},
    '{1'b1, 12'h3fc, 8'hff, 8'h00, 1'b1}};
  logic                         pclk;
  logic                         presetn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  adc_result_pkg::conv_result_s conv_in;
  adc_result_pkg::trig_flags_s  trig_flags;
  logic                         conv_start;
  logic                         cmp_mux_enable;
  logic [3:0]                   channel_select_bits;
  logic [31:0]                  rd;
  logic                         er;
  int                           n_mismatch;
  int                           total_checks;

  adc_result_readout dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_in(conv_in), .trig_flags(trig_flags), .conv_start(conv_start),
    .cmp_mux_enable(cmp_mux_enable), .channel_select_bits(channel_select_bits));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high or 20 cycles pass, then the test ends as failed
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t apb transfer timed out", $time);
      end_of_test();
    end
  endtask : apb

  task automatic conv(input logic [9:0] v);
    @(posedge pclk);
    conv_in <= '{done: 1'b1, value: v};
    @(posedge pclk);
    conv_in.done <= 1'b0;
  endtask : conv

  task automatic rdres(input logic [9:0] v, input logic left);
    apb(1'b0, adc_result_pkg::RESULT_LOW_ADDR, 8'h00);
    chk(rd, left ? {24'h000000, v[1:0], 6'h00} : {24'h000000, v[7:0]}, "low byte");
    apb(1'b0, adc_result_pkg::RESULT_HIGH_ADDR, 8'h00);
    chk(rd, left ? {24'h000000, v[9:2]} : {30'h00000000, v[9:8]}, "high byte");
  endtask : rdres

  task automatic trig(input logic [2:0] c, input logic [6:0] f, input logic exp);
    int   i;
    logic hit;
    apb(1'b1, adc_result_pkg::CTRL_B_ADDR, {5'h00, c});
    @(posedge pclk);
    trig_flags <= f;
    hit = 1'b0;
    for (i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      if (conv_start === 1'b1)
        hit = 1'b1;
    end
    chk({31'h0, hit}, {31'h0, exp}, "trigger start");
    trig_flags <= '0;
  endtask : trig

  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    conv_in = '0;
    trig_flags = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({26'h0, conv_start, cmp_mux_enable, channel_select_bits}, 32'h0, "reset outs");
    // table of register accesses
    foreach (ROWS[k])
    begin
      apb(ROWS[k].wr, ROWS[k].a, ROWS[k].d);
      if (!ROWS[k].wr)
        chk(rd, {24'h000000, ROWS[k].e}, "reg read");
      chk({31'h0, er}, {31'h0, ROWS[k].err}, "slave error");
    end
    chk({31'h0, cmp_mux_enable}, 32'h1, "mux enable out");
    apb(1'b1, adc_result_pkg::MUX_SELECT_ADDR, 8'h0f);
    @(posedge pclk);
    chk({28'h0, channel_select_bits}, 32'hf, "channel out");
    apb(1'b1, adc_result_pkg::MUX_SELECT_ADDR, 8'h00);
    conv(10'h2a5);
    rdres(10'h2a5, 1'b0);
    apb(1'b1, adc_result_pkg::MUX_SELECT_ADDR, 8'h20);
    rdres(10'h2a5, 1'b1);
    conv(10'h1c6);
    rdres(10'h1c6, 1'b1);
    // left layout, high byte alone never freezes
    conv(10'h0ff);
    apb(1'b0, adc_result_pkg::RESULT_HIGH_ADDR, 8'h00);
    chk(rd, 32'h3f, "high only");
    conv(10'h3c1);
    apb(1'b0, adc_result_pkg::RESULT_HIGH_ADDR, 8'h00);
    chk(rd, 32'hf0, "high only again");
    apb(1'b1, adc_result_pkg::MUX_SELECT_ADDR, 8'h00);
    // freeze between low and high reads
    conv(10'h3f3);
    apb(1'b0, adc_result_pkg::RESULT_LOW_ADDR, 8'h00);
    chk(rd, 32'hf3, "frozen low");
    apb(1'b0, adc_result_pkg::STATUS_ADDR, 8'h00);
    chk(rd, 32'h1, "status frozen");
    conv(10'h10c);
    apb(1'b0, adc_result_pkg::STATUS_ADDR, 8'h00);
    chk(rd, 32'h3, "status pending");
    apb(1'b0, adc_result_pkg::RESULT_HIGH_ADDR, 8'h00);
    chk(rd, 32'h3, "frozen high");
    rdres(10'h10c, 1'b0);
    // trigger sources
    apb(1'b1, adc_result_pkg::CTRL_A_ADDR, 8'ha0);
    for (int k = 1; k < 8; k++)
      trig(k[2:0], 7'h01 << (k - 1), 1'b1);
    trig(3'h2, 7'h7d, 1'b0);
    trig(3'h0, 7'h7f, 1'b0);
    apb(1'b1, adc_result_pkg::CTRL_A_ADDR, 8'h80);
    trig(3'h1, 7'h01, 1'b0);
    // mid-run reset clears registers, outputs and freeze
    apb(1'b1, adc_result_pkg::CTRL_B_ADDR, 8'h41);
    apb(1'b1, adc_result_pkg::MUX_SELECT_ADDR, 8'h25);
    conv(10'h155);
    apb(1'b0, adc_result_pkg::RESULT_LOW_ADDR, 8'h00);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({26'h0, conv_start, cmp_mux_enable, channel_select_bits}, 32'h0, "outs again");
    apb(1'b0, adc_result_pkg::STATUS_ADDR, 8'h00);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, adc_result_pkg::CTRL_B_ADDR, 8'h00);
    chk(rd, 32'h0, "control b after reset");
    rdres(10'h000, 1'b0);
    end_of_test();
  end
endmodule : adc_result_readout_tb_top
`default_nettype wire
